/* design/ltg_defs.svh */
// Timing figures, clock rate and reset values of the tone gate block
`ifndef LTG_DEFS_SVH
`define LTG_DEFS_SVH

// Core clock
`define LTG_CLK_HZ 10000000
`define LTG_CLK_PERIOD_NS 100

// Internal tone frequency
`define LTG_TONE_HZ 22000

// External tone mode: gate start after detection, stop after last edge
`define LTG_EXT_ON_NS 1000
`define LTG_EXT_OFF_NS 60000

// Envelope mode: start after rise, stop after fall (short end of range)
`define LTG_ENV_ON_NS 6000
`define LTG_ENV_OFF_NS 15000

// Widths and reset values
`define LTG_LEVEL_W 4
`define LTG_CNT_W 10
`define LTG_CTRL_RST 6'h00
`define LTG_DIAG_RST 3'h0

`endif

/* design/ltg_pkg.sv */
// Types shared by the tone gate and diagnostic block
package ltg_pkg;

    // Control word written by the host: level, mode and tone enable
    typedef struct packed {
        logic [3:0] output_level;
        logic external_tone_mode;
        logic tone_enable_bit;
    } ltg_ctrl_t;

    // Latched diagnostic flags
    typedef struct packed {
        logic overtemp_flag;
        logic overload_flag;
        logic supply_low_flag;
    } ltg_diag_t;

    // Tone gate states, Gray coded along idle, arm, on, hold
    typedef enum logic [1:0] {
        GATE_IDLE = 2'b00,
        GATE_ARM = 2'b01,
        GATE_ON = 2'b11,
        GATE_HOLD = 2'b10
    } ltg_gate_st_t;

endpackage

/* design/ltg_sync.sv */
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none

module ltg_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // ltg_sync

`default_nettype wire

/* design/ltg_ctrl.sv */
// Tone gating, diagnostic flags and supply lockout of the LNB supply control
`timescale 1ns/1ps
`default_nettype none

`include "ltg_defs.svh"

// What this block does
// - Both mode bits set: tone follows key waveform
// - External mode: key sets frequency and duty
// - External mode: start ~1us, stop ~60us
// - Envelope mode: internal tone while key high
// - Envelope: start ~6us, stop 15-60us after
// - Continuous tone: key high, tone enable set, external mode clear
// - Three diagnostic flags, low when no fault
// - Flag holds until cause gone and read
// - Four-bit output level field, host writable
// - Under lockout: ignore writes, control register zero
// - Writes accepted only once supply is good
// - Low supply sets flag, drives fault low
// - Overload sets flag, clears after read
// - Overtemperature shuts output stage, sets flag
module ltg_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic link_wr,
    input wire ltg_pkg::ltg_ctrl_t link_wdata,
    input wire logic link_rd,
    output var ltg_pkg::ltg_diag_t link_status,
    input wire logic supply_ok,
    input wire logic supply_lpd_low,
    input wire logic overload_det,
    input wire logic overtemp_det,
    input wire logic tone_key_input,
    output var logic tone_out,
    output var logic [3:0] output_level,
    output var logic output_stage_en,
    output var logic fault_output_n,
    output var ltg_pkg::ltg_ctrl_t output_level_reg,
    output var ltg_pkg::ltg_diag_t diag_status_reg
);
    import ltg_pkg::*;

    localparam int CW = `LTG_CNT_W;

    // Least time in ns to whole core cycles, never below one
    function automatic logic [CW-1:0] ns_to_cyc(input int t_ns);
        int c;
        c = (t_ns + `LTG_CLK_PERIOD_NS - 1) / `LTG_CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return CW'(c);
    endfunction

    localparam logic [CW-1:0] EXT_ON_CYC = ns_to_cyc(`LTG_EXT_ON_NS);
    localparam logic [CW-1:0] EXT_OFF_CYC = ns_to_cyc(`LTG_EXT_OFF_NS);
    localparam logic [CW-1:0] ENV_ON_CYC = ns_to_cyc(`LTG_ENV_ON_NS);
    localparam logic [CW-1:0] ENV_OFF_CYC = ns_to_cyc(`LTG_ENV_OFF_NS);
    localparam logic [CW-1:0] HALF_TONE_CYC =
        CW'(`LTG_CLK_HZ / (2 * `LTG_TONE_HZ));
    localparam logic [CW-1:0] ONE = CW'(1);

    // Link clock domain

    ltg_ctrl_t wr_hold_r;
    logic wr_tgl_r;
    logic rd_tgl_r;
    ltg_diag_t link_status_r;
    logic [2:0] diag_link_s;

    // Write data is held stable while its toggle crosses to the core
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            wr_hold_r <= `LTG_CTRL_RST;
            wr_tgl_r <= 1'b0;
            rd_tgl_r <= 1'b0;
            link_status_r <= `LTG_DIAG_RST;
        end else begin
            if (link_wr) begin
                wr_hold_r <= link_wdata;
                wr_tgl_r <= ~wr_tgl_r;
            end
            if (link_rd) begin
                rd_tgl_r <= ~rd_tgl_r;
            end
            link_status_r <= ltg_diag_t'(diag_link_s);
        end
    end

    assign link_status = link_status_r;

    // Flags are independent levels, so a per-bit synchroniser suffices
    ltg_sync #(.W(3)) u_sync_diag (
        .clk(link_clk),
        .resetn(resetn),
        .d(diag_status_reg),
        .q(diag_link_s)
    );

    // Core clock domain

    logic [4:0] pins_s;
    logic [1:0] tgl_s;
    logic uvlo_ok;
    logic lpd_s;
    logic ovl_s;
    logic ot_s;
    logic key_s;

    ltg_sync #(.W(5)) u_sync_pins (
        .clk(clk),
        .resetn(resetn),
        .d({supply_ok, supply_lpd_low, overload_det, overtemp_det,
            tone_key_input}),
        .q(pins_s)
    );

    ltg_sync #(.W(2)) u_sync_tgl (
        .clk(clk),
        .resetn(resetn),
        .d({wr_tgl_r, rd_tgl_r}),
        .q(tgl_s)
    );

    assign uvlo_ok = pins_s[4];
    assign lpd_s = pins_s[3];
    assign ovl_s = pins_s[2];
    assign ot_s = pins_s[1];
    assign key_s = pins_s[0];

    logic wr_seen_r;
    logic rd_seen_r;
    logic wr_evt;
    logic rd_evt;

    assign wr_evt = tgl_s[1] ^ wr_seen_r;
    assign rd_evt = (tgl_s[0] ^ rd_seen_r) & uvlo_ok;

    // Control register
    ltg_ctrl_t ctrl_r;
    ltg_ctrl_t ctrl_nxt;

    assign ctrl_nxt = !uvlo_ok ? ltg_ctrl_t'(`LTG_CTRL_RST) :
                      wr_evt ? wr_hold_r : ctrl_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `LTG_CTRL_RST;
            wr_seen_r <= 1'b0;
            rd_seen_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            wr_seen_r <= tgl_s[1];
            rd_seen_r <= tgl_s[0];
        end
    end

    assign output_level_reg = ctrl_r;
    assign output_level = ctrl_r.output_level;

    // Diagnostic flags
    ltg_diag_t diag_r;
    ltg_diag_t diag_nxt;
    logic fault_n_r;
    logic stage_en_r;

    // set wins, clear needs read and no cause
    assign diag_nxt.overtemp_flag =
        ot_s | (diag_r.overtemp_flag & ~rd_evt);
    assign diag_nxt.overload_flag =
        ovl_s | (diag_r.overload_flag & ~rd_evt);
    assign diag_nxt.supply_low_flag =
        lpd_s | (diag_r.supply_low_flag & ~rd_evt);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            diag_r <= `LTG_DIAG_RST;
            fault_n_r <= 1'b1;
            stage_en_r <= 1'b0;
        end else begin
            diag_r <= diag_nxt;
            fault_n_r <= ~(|diag_nxt);
            stage_en_r <= uvlo_ok & ~ot_s & (|ctrl_nxt.output_level);
        end
    end

    assign diag_status_reg = diag_r;
    assign fault_output_n = fault_n_r;
    assign output_stage_en = stage_en_r;

    // Internal tone generator, restarted high as the gate opens
    logic [CW-1:0] tone_cnt_r;
    logic int_tone_r;
    logic tone_wrap;
    logic tone_restart;

    assign tone_wrap = (tone_cnt_r == HALF_TONE_CYC - ONE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tone_cnt_r <= '0;
            int_tone_r <= 1'b0;
        end else if (tone_restart) begin
            tone_cnt_r <= '0;
            int_tone_r <= 1'b1;
        end else begin
            tone_cnt_r <= tone_wrap ? '0 : tone_cnt_r + ONE;
            if (tone_wrap) begin
                int_tone_r <= ~int_tone_r;
            end
        end
    end

    // Tone gate decoding
    logic key_d_r;
    logic key_edge;
    logic ext_mode;
    logic tone_armed;
    logic start_cond;
    logic quiet;
    logic abort_cond;
    logic [CW-1:0] on_cyc;
    logic [CW-1:0] off_cyc;

    assign key_edge = key_s ^ key_d_r;
    assign ext_mode = ctrl_r.external_tone_mode;
    // mode bits must precede the waveform
    assign tone_armed = uvlo_ok & ctrl_r.tone_enable_bit;
    // external start on any key edge
    assign start_cond = ext_mode ? key_edge : key_s;
    assign quiet = ext_mode ? ~key_edge : ~key_s;
    assign abort_cond = ~ext_mode & ~key_s;
    assign on_cyc = ext_mode ? EXT_ON_CYC : ENV_ON_CYC;
    assign off_cyc = ext_mode ? EXT_OFF_CYC : ENV_OFF_CYC;

    ltg_gate_st_t st_r;
    ltg_gate_st_t st_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // tone begins as soon as the gate opens
    assign tone_restart = (st_r == GATE_ARM) & (st_nxt == GATE_ON);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        if (!tone_armed) begin
            st_nxt = GATE_IDLE;
            cnt_nxt = '0;
        end else begin
            case (st_r)
                GATE_IDLE: begin
                    cnt_nxt = '0;
                    if (start_cond) begin
                        st_nxt = GATE_ARM;
                    end
                end
                GATE_ARM: begin
                    if (abort_cond) begin
                        st_nxt = GATE_IDLE;
                        cnt_nxt = '0;
                    end else if (cnt_r >= on_cyc - ONE) begin
                        st_nxt = GATE_ON;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + ONE;
                    end
                end
                GATE_ON: begin
                    cnt_nxt = '0;
                    if (quiet) begin
                        st_nxt = GATE_HOLD;
                    end
                end
                GATE_HOLD: begin
                    if (!quiet) begin
                        st_nxt = GATE_ON;
                        cnt_nxt = '0;
                    end else if (cnt_r >= off_cyc - ONE) begin
                        st_nxt = GATE_IDLE;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + ONE;
                    end
                end
                default: begin
                    st_nxt = GATE_IDLE;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    logic gate;
    logic tone_sel;
    logic tone_out_r;

    assign gate = (st_r == GATE_ON) | (st_r == GATE_HOLD);
    // continuous tone with key held high
    assign tone_sel = ext_mode ? key_s : int_tone_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= GATE_IDLE;
            cnt_r <= '0;
            key_d_r <= 1'b0;
            tone_out_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            key_d_r <= key_s;
            tone_out_r <= gate & tone_sel & tone_armed;
        end
    end

    assign tone_out = tone_out_r;

endmodule // ltg_ctrl

`default_nettype wire

/* test/ltg_host_model.sv */
// Host link model: write and status-read frames on a gated link clock
`timescale 1ns/1ps
`default_nettype none

module ltg_host_model (
    output var logic link_clk,
    output var logic link_wr,
    output var ltg_pkg::ltg_ctrl_t link_wdata,
    output var logic link_rd
);
    import ltg_pkg::*;

    initial begin
        link_clk = 1'b0;
        link_wr = 1'b0;
        link_rd = 1'b0;
        link_wdata = 6'h00;
    end

    // whole word, request dropped after its edge
    task automatic xfer(input logic wr, input logic rd, input ltg_ctrl_t w);
        link_wr = wr;
        link_rd = rd;
        link_wdata = w;
        repeat (10) begin
            #40 link_clk = 1'b1;
            link_wr <= 1'b0;
            link_rd <= 1'b0;
            link_wdata <= ~w;
            #40 link_clk = 1'b0;
        end
    endtask
endmodule // ltg_host_model

`default_nettype wire

/* test/ltg_ctrl_properties.sv */
// Concurrent checks on the tone gate block ports
`timescale 1ns/1ps
`default_nettype none

module ltg_ctrl_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_ok,
    input wire logic supply_lpd_low,
    input wire logic overload_det,
    input wire logic overtemp_det,
    input wire logic tone_key_input,
    input wire logic tone_out,
    input wire logic [3:0] output_level,
    input wire logic output_stage_en,
    input wire logic fault_output_n,
    input wire ltg_pkg::ltg_ctrl_t output_level_reg,
    input wire ltg_pkg::ltg_diag_t diag_status_reg
);
    import ltg_pkg::*;
    logic [9:0] lo_r;
    wire logic [9:0] lo_nxt;
    wire logic env_w;
    // Cycles the key has been low, saturating
    assign lo_nxt = tone_key_input ? 10'h000 : lo_r + {9'h000, lo_r != 10'h3ff};
    assign env_w = output_level_reg.tone_enable_bit
        && !output_level_reg.external_tone_mode;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lo_r <= 10'h000;
        end else begin
            lo_r <= lo_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_hot; overtemp_det [*5]; endsequence
    sequence s_ovl; overload_det [*5]; endsequence
    sequence s_low; supply_lpd_low [*6]; endsequence
    lockout_zero_a: assert property (
        !supply_ok [*5] |-> output_level_reg == 6'h00)
        else $error("word kept in lockout");
    level_stage_a: assert property (
        output_stage_en |-> output_level != 4'h0)
        else $error("stage on with zero level");
    hot_shutdown_a: assert property (
        s_hot |-> !output_stage_en && diag_status_reg.overtemp_flag)
        else $error("hot not handled");
    overload_flag_a: assert property (
        s_ovl |-> diag_status_reg.overload_flag)
        else $error("overload not flagged");
    supply_low_a: assert property (
        s_low |-> diag_status_reg.supply_low_flag && !fault_output_n)
        else $error("low supply not flagged");
    fault_idle_a: assert property (
        (diag_status_reg == 3'h0) [*2] |-> fault_output_n)
        else $error("fault without flag");
    tone_off_a: assert property (
        !output_level_reg.tone_enable_bit [*3] |-> !tone_out)
        else $error("tone while disabled");
    env_stop_a: assert property (
        env_w && lo_r >= 10'h0aa |-> !tone_out)
        else $error("tone outlasts key");
endmodule // ltg_ctrl_properties

bind ltg_ctrl ltg_ctrl_properties u_props (
    .clk(clk), .resetn(resetn), .supply_ok(supply_ok),
    .supply_lpd_low(supply_lpd_low), .overload_det(overload_det),
    .overtemp_det(overtemp_det), .tone_key_input(tone_key_input),
    .tone_out(tone_out), .output_level(output_level),
    .output_stage_en(output_stage_en), .fault_output_n(fault_output_n),
    .output_level_reg(output_level_reg), .diag_status_reg(diag_status_reg)
);

`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the tone gate and diagnostic block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ltg_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic supply_ok = 1'b0;
    logic supply_lpd_low = 1'b0;
    logic overload_det = 1'b0;
    logic overtemp_det = 1'b0;
    logic tone_key_input = 1'b0;
    wire logic link_clk, link_wr, link_rd, tone_out, output_stage_en;
    wire logic fault_output_n;
    wire logic [3:0] output_level;
    wire ltg_ctrl_t link_wdata, output_level_reg;
    wire ltg_diag_t link_status, diag_status_reg;
    int n_fail = 0;
    int samples_checked = 0;
    int n;

    always #50 clk = ~clk;

    ltg_host_model host (.link_clk(link_clk), .link_wr(link_wr),
        .link_wdata(link_wdata), .link_rd(link_rd));
    ltg_ctrl dut (.clk(clk), .resetn(resetn), .link_clk(link_clk),
        .link_wr(link_wr), .link_wdata(link_wdata), .link_rd(link_rd),
        .link_status(link_status), .supply_ok(supply_ok),
        .supply_lpd_low(supply_lpd_low), .overload_det(overload_det),
        .overtemp_det(overtemp_det), .tone_key_input(tone_key_input),
        .tone_out(tone_out), .output_level(output_level),
        .output_stage_en(output_stage_en), .fault_output_n(fault_output_n),
        .output_level_reg(output_level_reg),
        .diag_status_reg(diag_status_reg));

    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("FAIL %0t count %0d", $time, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic till(input logic v, input int lim, output int k);
        k = 0;
        while (tone_out !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic wr(input ltg_ctrl_t w);
        host.xfer(1'b1, 1'b0, w);
        cyc(6);
    endtask
    task automatic rd;
        host.xfer(1'b0, 1'b1, 6'h00);
        cyc(6);
    endtask
    task automatic key_wave(input int k);
        repeat (k) begin
            @(posedge clk) tone_key_input <= 1'b1;
            repeat (150) @(posedge clk);
            tone_key_input <= 1'b0;
            repeat (300) @(posedge clk);
        end
    endtask
    task automatic diag(input logic [5:0] exp);
        chk({fault_output_n, output_stage_en, 1'b0, diag_status_reg}, exp);
    endtask

    task automatic t_lock;
        wr(6'h23);
        chk(output_level_reg, 6'h00);
        @(posedge clk) supply_ok <= 1'b1;
        cyc(4);
        wr(6'h23);
        chk(output_level_reg, 6'h23);
        chk({2'h0, output_level}, 6'h08);
        @(posedge clk) supply_ok <= 1'b0;
        cyc(5);
        chk(output_level_reg, 6'h00);
        @(posedge clk) supply_ok <= 1'b1;
        cyc(4);
    endtask
    task automatic t_cont;
        @(posedge clk) tone_key_input <= 1'b1;
        wr(6'h11);
        till(1'b1, 400, n);
        till(1'b0, 300, n);
        till(1'b1, 300, n);
        rng(n, 226, 228);
        wr(6'h10);
        cyc(3);
        chk({5'h00, tone_out}, 6'h00);
    endtask
    task automatic t_env;
        @(posedge clk) tone_key_input <= 1'b0;
        wr(6'h11);
        cyc(200);
        @(posedge clk) tone_key_input <= 1'b1;
        till(1'b1, 300, n);
        rng(n, 55, 75);
        cyc(400);
        @(posedge clk) tone_key_input <= 1'b0;
        n = 0;
        for (int i = 1; i < 700; i++) begin
            @(negedge clk);
            if (tone_out === 1'b1) n = i;
        end
        rng(n, 150, 600);
    endtask
    task automatic t_ext;
        wr(6'h13);
        fork
            key_wave(3);
            begin
                till(1'b1, 40, n);
                rng(n, 5, 20);
                till(1'b0, 200, n);
                till(1'b1, 400, n);
                till(1'b0, 200, n);
                rng(n, 149, 151);
            end
        join
        @(posedge clk) tone_key_input <= 1'b1;
        till(1'b1, 20, n);
        till(1'b0, 700, n);
        rng(n, 590, 610);
        cyc(5);
        chk({5'h00, tone_out}, 6'h00);
        @(posedge clk) tone_key_input <= 1'b0;
    endtask
    task automatic t_diag;
        @(posedge clk) overload_det <= 1'b1;
        cyc(6);
        diag(6'h12);
        rd;
        diag(6'h12);
        chk({3'h0, link_status}, 6'h02);
        @(posedge clk) overload_det <= 1'b0;
        cyc(20);
        diag(6'h12);
        rd;
        diag(6'h30);
        chk({3'h0, link_status}, 6'h00);
        @(posedge clk) overtemp_det <= 1'b1;
        supply_lpd_low <= 1'b1;
        cyc(6);
        diag(6'h05);
        @(posedge clk) overtemp_det <= 1'b0;
        supply_lpd_low <= 1'b0;
        cyc(6);
        rd;
        diag(6'h30);
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        cyc(3);
        diag(6'h20);
        t_lock;
        t_cont;
        t_env;
        t_ext;
        t_diag;
        wrap_up;
    end
    initial begin
        #2000000;
        n_fail++;
        wrap_up;
    end
endmodule // tb_top

`default_nettype wire
